//--- common/eew_consts.vh
// Constants for the erase/write controller
`ifndef EEW_CONSTS_VH
`define EEW_CONSTS_VH
`define EEW_CLK_MHZ        10
`define EEW_PULSE_MIN_MS   9
`define EEW_PULSE_MAX_MS   70
`define EEW_PULSE_MS       10
`define EEW_POST_WRITE_US  40
`define EEW_US_PER_MS      1000
`define EEW_CNT_W          20
`define EEW_ADDR_W         11
`define EEW_DATA_W         8
`define EEW_ERASED_BYTE    8'hFF
`define EEW_CMD_WRITE      2'h0
`define EEW_CMD_ERASE      2'h1
`define EEW_CMD_CHIP       2'h2
`define EEW_CMD_READ       2'h3
`define EEW_SYNC_W         2
`define EEW_SETUP_CYC      2
`endif

//--- rtl/eew_sync.v
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module eew_sync #(
    parameter W = 1
) (
    input  wire         i_clk,
    input  wire         i_rstn,
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    meta_ff[g] <= 1'b0;
                    sync_ff[g] <= 1'b0;
                end else begin
                    meta_ff[g] <= i_d[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate
    assign o_q = sync_ff;
endmodule

//--- rtl/eew_ctrl.v
// Host controller driving the erasable memory pins
`timescale 1ns/1ps
`include "eew_consts.vh"
// Notes on behaviour
// - Keep enable strobes high when idle
// - Programming pin raised, output enable high
// - Strobe held nine to seventy ms
// - Wait forty microseconds after each write
// - Erase byte with ones before writing
// - Chip erase: high output enable, ones
module eew_ctrl #(
    parameter [`EEW_CNT_W-1:0] PULSE_CYC = `EEW_PULSE_MS * `EEW_US_PER_MS * `EEW_CLK_MHZ,
    parameter [`EEW_CNT_W-1:0] GAP_CYC   = `EEW_POST_WRITE_US * `EEW_CLK_MHZ
) (
    input  wire                   i_clk,
    input  wire                   i_rstn,
    input  wire                   i_req,
    input  wire [1:0]             i_cmd,
    input  wire [`EEW_ADDR_W-1:0] i_addr,
    input  wire [`EEW_DATA_W-1:0] i_wdata,
    input  wire                   i_supply_ok,
    input  wire [`EEW_DATA_W-1:0] i_mem_dq,
    output wire                   o_ready,
    output reg                    o_done,
    output reg  [`EEW_DATA_W-1:0] o_rdata,
    output reg                    o_mem_ce_n,
    output reg                    o_mem_oe_n,
    output reg                    o_mem_we_n,
    output reg                    o_mem_oe_hv,
    output reg                    o_mem_vpp_hi,
    output reg  [`EEW_ADDR_W-1:0] o_mem_addr,
    output reg  [`EEW_DATA_W-1:0] o_mem_dq,
    output reg                    o_mem_dq_oe
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_PULSE = 3'h2;
    localparam ST_GAP   = 3'h3;
    localparam ST_READ  = 3'h4;
    localparam [`EEW_CNT_W-1:0] PULSE_N = PULSE_CYC;
    localparam [`EEW_CNT_W-1:0] GAP_N   = GAP_CYC;
    localparam [`EEW_CNT_W-1:0] SETUP_N = `EEW_SETUP_CYC;

    wire [`EEW_DATA_W:0] sync_q;
    wire                 supply_ok_s = sync_q[`EEW_DATA_W];
    eew_sync #(.W(`EEW_DATA_W + 1)) u_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_d    ({i_supply_ok, i_mem_dq}),
        .o_q    (sync_q)
    );

    reg [2:0]             state_ff;
    reg [`EEW_CNT_W-1:0]  cnt_ff;
    reg [1:0]             cmd_ff;
    reg                   phase2_ff;
    reg                   abort_ff;
    reg [`EEW_DATA_W-1:0] data_ff;
    reg                   cmd_is_read;
    reg                   cmd_is_chip;

    wire cnt_zero      = (cnt_ff == {`EEW_CNT_W{1'b0}});
    wire pulse_end     = cnt_zero || !supply_ok_s;
    // A cut erase pulse leaves the byte unknown, so no data pass may follow
    wire data_pass_due = (cmd_ff == `EEW_CMD_WRITE) && !phase2_ff && !abort_ff && supply_ok_s;
    wire start_ok      = i_req && o_ready;

    assign o_ready = (state_ff == ST_IDLE) && supply_ok_s;

    // Request decode; byte erase and write share the erase-first pass
    always @* begin
        cmd_is_read = 1'b0;
        cmd_is_chip = 1'b0;
        case (i_cmd)
            `EEW_CMD_WRITE: begin
                cmd_is_read = 1'b0;
            end
            `EEW_CMD_ERASE: begin
                cmd_is_read = 1'b0;
            end
            `EEW_CMD_CHIP: begin
                cmd_is_chip = 1'b1;
            end
            `EEW_CMD_READ: begin
                cmd_is_read = 1'b1;
            end
            default: begin
                cmd_is_read = 1'b0;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff     <= ST_IDLE;
            cnt_ff       <= {`EEW_CNT_W{1'b0}};
            cmd_ff       <= `EEW_CMD_READ;
            phase2_ff    <= 1'b0;
            abort_ff     <= 1'b0;
            data_ff      <= {`EEW_DATA_W{1'b0}};
            o_done       <= 1'b0;
            o_rdata      <= {`EEW_DATA_W{1'b0}};
            o_mem_ce_n   <= 1'b1;
            o_mem_oe_n   <= 1'b1;
            o_mem_we_n   <= 1'b1;
            o_mem_oe_hv  <= 1'b0;
            o_mem_vpp_hi <= 1'b0;
            o_mem_addr   <= {`EEW_ADDR_W{1'b0}};
            o_mem_dq     <= {`EEW_DATA_W{1'b0}};
            o_mem_dq_oe  <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    o_mem_ce_n   <= 1'b1;
                    o_mem_we_n   <= 1'b1;
                    o_mem_oe_n   <= 1'b1;
                    o_mem_oe_hv  <= 1'b0;
                    o_mem_vpp_hi <= 1'b0;
                    o_mem_dq_oe  <= 1'b0;
                    if (start_ok) begin
                        cmd_ff     <= i_cmd;
                        o_mem_addr <= i_addr;
                        data_ff    <= i_wdata;
                        phase2_ff  <= 1'b0;
                        abort_ff   <= 1'b0;
                        cnt_ff     <= SETUP_N;
                        o_mem_ce_n <= 1'b0;
                        if (cmd_is_read) begin
                            state_ff   <= ST_READ;
                            o_mem_oe_n <= 1'b0;
                        end else begin
                            // Erase pass first for write, byte erase and chip erase
                            state_ff    <= ST_SETUP;
                            o_mem_dq    <= `EEW_ERASED_BYTE;
                            o_mem_dq_oe <= 1'b1;
                            o_mem_oe_hv <= cmd_is_chip;
                        end
                    end
                end
                ST_SETUP: begin
                    // Address and data settle before strobe
                    o_mem_vpp_hi <= 1'b1;
                    if (cnt_ff == {`EEW_CNT_W{1'b0}}) begin
                        state_ff   <= ST_PULSE;
                        cnt_ff     <= PULSE_N;
                        o_mem_we_n <= 1'b0;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                ST_PULSE: begin
                    // Pulse ends at the fixed PULSE_N count (10 ms by default), or early when the supply drops
                    if (pulse_end) begin
                        if (!supply_ok_s) begin
                            abort_ff <= 1'b1;
                        end
                        state_ff     <= ST_GAP;
                        cnt_ff       <= GAP_N;
                        o_mem_we_n   <= 1'b1;
                        o_mem_ce_n   <= 1'b1;
                        o_mem_oe_hv  <= 1'b0;
                        o_mem_vpp_hi <= 1'b0;
                        o_mem_dq_oe  <= 1'b0;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                ST_GAP: begin
                    if (cnt_zero) begin
                        if (data_pass_due) begin
                            state_ff    <= ST_SETUP;
                            phase2_ff   <= 1'b1;
                            cnt_ff      <= SETUP_N;
                            o_mem_ce_n  <= 1'b0;
                            o_mem_dq    <= data_ff;
                            o_mem_dq_oe <= 1'b1;
                        end else begin
                            state_ff <= ST_IDLE;
                            o_done   <= 1'b1;
                        end
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                ST_READ: begin
                    // Wait out access plus synchroniser latency
                    if (cnt_ff == {`EEW_CNT_W{1'b0}}) begin
                        o_rdata    <= sync_q[`EEW_DATA_W-1:0];
                        o_done     <= 1'b1;
                        o_mem_ce_n <= 1'b1;
                        o_mem_oe_n <= 1'b1;
                        state_ff   <= ST_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- tb/eew_mem_model.sv
// Behavioural erasable memory answering the controller pins
`timescale 1ns/1ps
module eew_mem_model #(parameter MIN_NS = 2000) (
    input  wire        i_vcc_ok, i_ce_n, i_oe_n, i_we_n, i_oe_hv, i_vpp_hi, i_dq_oe,
    input  wire [10:0] i_addr,
    input  wire [7:0]  i_dq,
    output wire [7:0]  o_dq
);
    reg [7:0] mem [0:2047];
    reg [7:0] last_q, dat;
    reg [10:0] adr;
    reg ok, hv;
    realtime t0;
    integer k;
    wire rd = !i_ce_n && !i_oe_n && i_we_n;
    // Released bus never holds its last value
    assign o_dq = rd ? mem[i_addr] : ~last_q;
    initial begin
        last_q = 8'h00;
        for (k = 0; k < 2048; k = k + 1) mem[k] = 8'h3C;
    end
    always @(negedge rd) last_q = mem[i_addr];
    // Latch at pulse start: strobes may rise together at the end
    always @(negedge i_we_n) begin
        t0 = $realtime;
        ok = i_vcc_ok && !i_ce_n && i_vpp_hi && i_dq_oe;
        hv = i_oe_hv;
        adr = i_addr;
        dat = i_dq;
    end
    always @(negedge i_vcc_ok) ok = 1'b0;
    always @(posedge i_we_n) begin
        if (ok && $realtime - t0 >= MIN_NS && hv && dat == 8'hFF) begin
            for (k = 0; k < 2048; k = k + 1) mem[k] = 8'hFF;
        end else if (ok && $realtime - t0 >= MIN_NS && !hv) begin
            // Without a prior erase a write can only clear bits
            mem[adr] = (dat == 8'hFF) ? 8'hFF : (mem[adr] & dat);
        end
    end
endmodule

//--- tb/eew_ctrl_properties.sv
// Pin-level assertions for the erase/write controller
`timescale 1ns/1ps
module eew_ctrl_properties #(parameter PULSE_CYC = 20, parameter GAP_CYC = 5) (
    input wire        i_clk, i_rstn, o_ready, o_done, o_mem_ce_n, o_mem_oe_n,
    input wire        o_mem_we_n, o_mem_oe_hv, o_mem_vpp_hi, o_mem_dq_oe,
    input wire [10:0] o_mem_addr,
    input wire [7:0]  o_mem_dq
);
    reg [19:0] wcnt_ff, gcnt_ff;
    reg        pff_ff;
    reg [10:0] padr_ff;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wcnt_ff <= 20'h0;
            gcnt_ff <= 20'(GAP_CYC);
            pff_ff  <= 1'b0;
            padr_ff <= 11'h0;
        end else begin
            wcnt_ff <= o_mem_we_n ? 20'h0 : wcnt_ff + 20'h1;
            gcnt_ff <= !o_mem_we_n ? 20'h0 : (gcnt_ff >= GAP_CYC ? gcnt_ff : gcnt_ff + 20'h1);
            if (!o_mem_we_n) begin
                pff_ff  <= (o_mem_dq == 8'hFF);
                padr_ff <= o_mem_addr;
            end
        end
    end
    idle_strobes_a: assert property (o_ready |-> o_mem_ce_n && o_mem_we_n)
        else $error("strobe active while idle");
    pulse_mode_a: assert property (!o_mem_we_n |-> !o_mem_ce_n && o_mem_oe_n && o_mem_vpp_hi)
        else $error("pulse pin mode wrong");
    chip_ones_a: assert property (o_mem_oe_hv |-> o_mem_dq == 8'hFF && o_mem_dq_oe)
        else $error("chip erase data not ones");
    pulse_max_a: assert property (wcnt_ff <= PULSE_CYC + 1)
        else $error("pulse too long");
    pulse_stable_a: assert property (!o_mem_we_n && !$past(o_mem_we_n) |-> $stable(o_mem_dq))
        else $error("data moved in pulse");
    post_gap_a: assert property ($fell(o_mem_ce_n) |-> gcnt_ff >= GAP_CYC)
        else $error("recovery gap short");
    erase_first_a: assert property ($fell(o_mem_we_n) && o_mem_dq != 8'hFF |-> pff_ff && padr_ff == o_mem_addr)
        else $error("write without erase");
    read_quiet_a: assert property (!o_mem_oe_n |-> o_mem_we_n && !o_mem_dq_oe)
        else $error("read overlaps drive");
endmodule
bind eew_ctrl eew_ctrl_properties #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .o_ready(o_ready), .o_done(o_done),
    .o_mem_ce_n(o_mem_ce_n), .o_mem_oe_n(o_mem_oe_n), .o_mem_we_n(o_mem_we_n),
    .o_mem_oe_hv(o_mem_oe_hv), .o_mem_vpp_hi(o_mem_vpp_hi), .o_mem_dq_oe(o_mem_dq_oe),
    .o_mem_addr(o_mem_addr), .o_mem_dq(o_mem_dq));

//--- tb/eew_ctrl_tb_top.sv
// Self-checking bench for the erase/write controller
`timescale 1ns/1ps
module eew_ctrl_tb_top;
    localparam P = 20, G = 5;
    reg        i_clk, i_rstn, i_req, i_supply_ok;
    reg [1:0]  i_cmd;
    reg [10:0] i_addr;
    reg [7:0]  i_wdata;
    wire [7:0] mem_q, o_rdata, o_mem_dq;
    wire [10:0] o_mem_addr;
    wire o_ready, o_done, o_mem_ce_n, o_mem_oe_n, o_mem_we_n, o_mem_oe_hv, o_mem_vpp_hi, o_mem_dq_oe;
    integer miscompares = 0, total_checks = 0, lows;
    eew_ctrl #(.PULSE_CYC(P), .GAP_CYC(G)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req),
        .i_cmd(i_cmd), .i_addr(i_addr), .i_wdata(i_wdata), .i_supply_ok(i_supply_ok),
        .i_mem_dq(mem_q), .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata),
        .o_mem_ce_n(o_mem_ce_n), .o_mem_oe_n(o_mem_oe_n), .o_mem_we_n(o_mem_we_n),
        .o_mem_oe_hv(o_mem_oe_hv), .o_mem_vpp_hi(o_mem_vpp_hi), .o_mem_addr(o_mem_addr),
        .o_mem_dq(o_mem_dq), .o_mem_dq_oe(o_mem_dq_oe));
    eew_mem_model mem (.i_vcc_ok(i_supply_ok), .i_ce_n(o_mem_ce_n), .i_oe_n(o_mem_oe_n),
        .i_we_n(o_mem_we_n), .i_oe_hv(o_mem_oe_hv), .i_vpp_hi(o_mem_vpp_hi),
        .i_dq_oe(o_mem_dq_oe), .i_addr(o_mem_addr), .i_dq(o_mem_dq), .o_dq(mem_q));
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task op(input [1:0] c, input [10:0] a, input [7:0] d);
        integer n;
        @(negedge i_clk);
        {i_req, i_cmd, i_addr, i_wdata} = {1'b1, c, a, d};
        @(negedge i_clk);
        i_req = 1'b0;
        lows = 0;
        for (n = 0; n < 400 && o_done !== 1'b1; n = n + 1) begin
            if (o_mem_we_n === 1'b0) lows = lows + 1;
            @(negedge i_clk);
        end
        chk("done", o_done, 1);
    endtask
    task t_write;
        op(0, 11'h123, 8'h5A);
        chk("wlow", lows, 2 * (P + 1));
        op(0, 11'h123, 8'hA5);
        op(3, 11'h123, 8'h00);
        chk("wrd", o_rdata, 8'hA5);
    endtask
    task t_erase;
        op(1, 11'h123, 8'h00);
        chk("elow", lows, P + 1);
        op(3, 11'h123, 8'h00);
        chk("erd", o_rdata, 8'hFF);
    endtask
    task t_chip;
        op(0, 11'h7FF, 8'h00);
        op(2, 11'h000, 8'h00);
        op(3, 11'h7FF, 8'h00);
        chk("crd", o_rdata, 8'hFF);
        op(3, 11'h000, 8'h00);
        chk("crd0", o_rdata, 8'hFF);
    endtask
    // Refused request while supply is low must leave the byte intact
    task t_supply;
        op(0, 11'h055, 8'h11);
        i_supply_ok = 1'b0;
        repeat (3) @(negedge i_clk);
        chk("rdy", o_ready, 0);
        {i_req, i_cmd, i_wdata} = {1'b1, 2'h0, 8'h77};
        repeat (40) @(negedge i_clk);
        chk("we", o_mem_we_n & o_mem_ce_n, 1);
        i_req = 1'b0;
        i_supply_ok = 1'b1;
        repeat (3) @(negedge i_clk);
        op(3, 11'h055, 8'h00);
        chk("srd", o_rdata, 8'h11);
    endtask
    // Supply lost mid erase: the data pass must not follow
    task t_cut;
        fork
            op(0, 11'h200, 8'h41);
            begin
                wait (o_mem_we_n === 1'b0);
                repeat (5) @(negedge i_clk);
                i_supply_ok = 1'b0;
                repeat (3) @(negedge i_clk);
                i_supply_ok = 1'b1;
            end
        join
        chk("clow", lows < P + 1, 1);
        op(3, 11'h200, 8'h00);
        chk("cut", o_rdata, 8'hFF);
    endtask
    task print_verdict;
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        {i_rstn, i_req, i_cmd, i_addr, i_wdata, i_supply_ok} = 24'h1;
        repeat (6) @(negedge i_clk);
        chk("rst", o_mem_ce_n & o_mem_we_n, 1);
        i_rstn = 1'b1;
        repeat (3) @(negedge i_clk);
        t_write;
        t_erase;
        t_chip;
        t_supply;
        t_cut;
        print_verdict;
    end
    initial begin
        #1000000;
        miscompares = miscompares + 1;
        print_verdict;
    end
endmodule
